// ### rtl/scd_top.sv
// serial command decoder: link shifter plus command engine
//
// Summary of operation
// [R1] wake command ends power saving once its eighth clock has come
// [R2] sleep waits for the running conversion, keeps reference setting
// [R3] filter restart clears filter and starts a fresh conversion
// [R4] soft reset returns registers to power-up value and clears filter
// [R5] soft reset leaves the serial shifter alone; chip select realigns it
// [R6] soft reset holds registers and filter in reset for 0.6 ms
// [R7] bytes received during register readout are ignored
// [R8] read-once loads latest result for 24 shift clocks, any mode
// [R9] continuous readout starts loading at the second data-ready after the command
// [R10] host may stop a result read on any byte boundary
// [R11] host must finish readout before data-ready falls again
// [R12] stop-continuous ends auto loading after next data-ready
// [R13] read-once accepted during last byte of a result readout
// [R14] register read: start nibble, count nibble, wraps past 15
// [R15] register write stores count plus one bytes in sequence
// [R16] system offset calibration updates offset coefficient
// [R17] system gain calibration updates full-scale coefficient
// [R18] self offset calibration shorts inputs, updates offset coefficient
// [R19] internal reset held for 65536 clocks after power-up
// [R20] continuous readout is active after power-up
// [R21] four-bit register address; don't-care bits ignored
// [R22] sleep and wake act like the start pin low and high
// [R23] ready mode bit makes the output pin also show data ready
// [R24] msb first; unknown bytes act as no-operation
`timescale 1ns/1ps
module scd_top
  import scd_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int SOFT_RST_CYCLES = SOFT_RST_CYC
) (
  // system clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // serial link, host drives the clock
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic DATA_READY_N,
  // converter core side
  input wire logic CONV_DONE,
  input wire logic [23:0] CONV_RESULT,
  input wire logic CAL_DONE,
  input wire logic [23:0] CAL_COEF,
  output logic CONV_RUN,
  output logic FILTER_CLEAR,
  output logic INPUT_SHORT,
  output logic [1:0] CAL_KIND,
  output logic CAL_START,
  output logic IN_RESET,
  output logic [23:0] OFFSET_COEF,
  output logic [23:0] FULL_SCALE_COEF
);

  //////////////////////////////////////////////////////////////////////////
  // link domain: shift in on rise, shift out also on rise

  typedef struct packed {
    logic [2:0] bitcnt;
    logic [7:0] sh_in;
    scd_rx_t rx;
    logic [23:0] sh_out;
    logic [4:0] out_left;
    logic ld_seen;
  } scd_link_t;

  scd_link_t lk_q, lk_d;
  scd_tx_t tx_q;
  logic [7:0] rx_byte;
  logic ld_pend;

  // the link clock stands still between bytes, so it cannot run a
  // synchroniser; the load word and toggle only change in that gap
  // (bytes are spaced by at least 8 system clocks) and are settled
  // when the next byte starts. a host that skips the gap loses loads.
  assign ld_pend = tx_q.load_tgl != lk_q.ld_seen && lk_q.bitcnt == 3'd0;

  // shift in on each rise; a pending load shows its msb before the rise
  always_comb begin
    lk_d = lk_q;
    rx_byte = {lk_q.sh_in[6:0], DIN};
    lk_d.sh_in = rx_byte; // [R24]
    lk_d.bitcnt = lk_q.bitcnt + 3'd1;
    if (lk_q.bitcnt == 3'd7) begin
      lk_d.rx.byte_val = rx_byte;
      lk_d.rx.byte_tgl = ~lk_q.rx.byte_tgl;
    end
    if (ld_pend) begin
      lk_d.ld_seen = tx_q.load_tgl;
      lk_d.sh_out = {tx_q.word[22:0], 1'b0};
      lk_d.out_left = tx_q.nbits - 5'd1;
    end else if (lk_q.out_left != 5'd0) begin
      lk_d.sh_out = {lk_q.sh_out[22:0], 1'b0};
      lk_d.out_left = lk_q.out_left - 5'd1;
    end
  end

  // chip select high realigns the byte counter; soft reset does not
  // system reset aligns the toggles of both sides to zero
  always_ff @(posedge SCLK or posedge CS_N or posedge SYS_RST) begin
    if (SYS_RST) begin
      lk_q <= '0;
    end else if (CS_N) begin
      lk_q.bitcnt <= 3'd0; // [R5]
      lk_q.sh_in <= 8'h00;
    end else begin
      lk_q <= lk_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system domain command engine

  typedef enum {ST_IDLE, ST_RCNT, ST_RDATA, ST_WCNT, ST_WDATA,
                ST_CAL} scd_state_t;

  typedef struct packed {
    scd_state_t st;
    logic [2:0] rx_sync;
    logic rx_seen;
    logic [3:0] addr;
    logic [3:0] left;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [23:0] result;
    logic auto_load;
    logic auto_pend_on;
    logic auto_pend_off;
    logic sleep_pend;
    logic running;
    logic rdy_n;
    logic [16:0] rst_cnt;
    logic [1:0] cal;
    logic cal_go;
    logic fclr;
    logic [23:0] ofs;
    logic [23:0] fs;
    scd_tx_t tx;
    logic [4:0] busy_bits;
  } scd_sys_t;

  scd_sys_t s_q, s_d;
  logic rx_new;
  logic [7:0] cmd;

  // start a shift-out of n bits, msb aligned
  function automatic scd_tx_t start_tx(scd_tx_t t, logic [23:0] w,
                                       logic [4:0] n);
    scd_tx_t r;
    r = t;
    r.word = w;
    r.nbits = n;
    r.load_tgl = ~t.load_tgl;
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.rx_sync = {s_q.rx_sync[1:0], lk_q.rx.byte_tgl};
    rx_new = s_q.rx_sync[2] != s_q.rx_seen;
    cmd = lk_q.rx.byte_val; // stable well before the toggle arrives
    s_d.rx_seen = s_q.rx_sync[2];
    s_d.cal_go = 1'b0;
    s_d.fclr = 1'b0;
    // power-up and soft reset hold
    if (s_q.rst_cnt != 17'd0) begin
      s_d.rst_cnt = s_q.rst_cnt - 17'd1; // [R6] [R19]
      s_d.fclr = 1'b1;
      s_d.regs = '{default: REG_RESET_VAL}; // [R4]
    end else begin
      // conversion completion drives data-ready
      if (CONV_DONE && s_q.running) begin
        s_d.result = CONV_RESULT;
        s_d.rdy_n = 1'b0;
        if (s_q.auto_pend_on) begin
          s_d.auto_load = 1'b1; // [R9]
          s_d.auto_pend_on = 1'b0;
        end
        if (s_q.auto_pend_off) begin
          s_d.auto_load = 1'b0; // [R12]
          s_d.auto_pend_off = 1'b0;
        end
        if (s_q.auto_load && s_q.st != ST_RDATA)
          s_d.tx = start_tx(s_q.tx, CONV_RESULT, 5'd24); // [R11]
        if (s_q.sleep_pend) begin
          s_d.running = 1'b0; // [R2] [R22]
          s_d.sleep_pend = 1'b0;
        end
      end else if (rx_new) begin
        s_d.rdy_n = 1'b1;
      end
      if (s_q.st == ST_CAL && CAL_DONE) begin
        if (s_q.cal == 2'd1) s_d.fs = CAL_COEF; // [R17]
        else s_d.ofs = CAL_COEF; // [R16] [R18]
        s_d.st = ST_IDLE;
      end
      if (rx_new) begin
        unique case (s_q.st)
          ST_IDLE: begin
            if (cmd[7:1] == CMD_WAKE) begin
              s_d.running = 1'b1; // [R1] [R21]
              s_d.sleep_pend = 1'b0;
            end else if (cmd[7:1] == CMD_SLEEP) begin
              s_d.sleep_pend = 1'b1; // [R2]
            end else if (cmd[7:1] == CMD_SYNC) begin
              s_d.fclr = 1'b1; // [R3]
            end else if (cmd[7:1] == CMD_RESET) begin
              s_d.rst_cnt = 17'(SOFT_RST_CYCLES); // [R4] [R6]
              s_d.auto_load = 1'b1;
            end else if (cmd[7:1] == CMD_RDATA) begin
              s_d.tx = start_tx(s_q.tx, s_q.result, 5'd24); // [R8] [R13]
            end else if (cmd[7:1] == CMD_CONTINUOUS_READOUT_CMD) begin
              s_d.auto_pend_on = 1'b1; // [R9]
              s_d.auto_pend_off = 1'b0;
            end else if (cmd[7:1] == CMD_STOP_CONTINUOUS_CMD) begin
              s_d.auto_pend_off = 1'b1; // [R12]
              s_d.auto_pend_on = 1'b0;
            end else if (cmd[7:4] == CMD_REGISTER_READ_CMD_HI) begin
              s_d.addr = cmd[3:0]; // [R14]
              s_d.st = ST_RCNT;
            end else if (cmd[7:4] == CMD_REGISTER_WRITE_CMD_HI) begin
              s_d.addr = cmd[3:0]; // [R15]
              s_d.st = ST_WCNT;
            end else if (cmd == CMD_SYSTEM_OFFSET_CAL_CMD || cmd == CMD_SYSTEM_GAIN_CAL_CMD ||
                         cmd == CMD_SELF_OFFSET_CAL_CMD) begin
              s_d.cal = cmd[1:0];
              s_d.cal_go = 1'b1;
              s_d.st = ST_CAL;
            end
            // any other byte, NOP included, changes nothing [R24]
          end
          ST_RCNT: begin
            s_d.left = cmd[3:0];
            s_d.tx = start_tx(s_q.tx, {s_q.regs[s_q.addr], 16'h0000},
                              5'd8); // [R14]
            s_d.st = ST_RDATA;
          end
          ST_RDATA: begin
            // received byte is ignored, only paces the readout [R7]
            if (s_q.left == 4'd0) begin
              s_d.st = ST_IDLE;
            end else begin
              s_d.left = s_q.left - 4'd1;
              s_d.addr = s_q.addr + 4'd1; // [R14]
              s_d.tx = start_tx(s_q.tx,
                                {s_q.regs[s_q.addr + 4'd1], 16'h0000},
                                5'd8);
            end
          end
          ST_WCNT: begin
            s_d.left = cmd[3:0];
            s_d.st = ST_WDATA;
          end
          ST_WDATA: begin
            s_d.regs[s_q.addr] = cmd; // [R15]
            s_d.addr = s_q.addr + 4'd1;
            s_d.left = s_q.left - 4'd1;
            if (s_q.left == 4'd0) s_d.st = ST_IDLE;
          end
          ST_CAL: begin
          end
        endcase
      end
    end
  end

  // synchronous reset starts the power-up hold
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.rst_cnt <= 17'(POR_CYCLES); // [R19]
      s_q.auto_load <= 1'b1; // [R20]
      s_q.running <= 1'b1;
      s_q.rdy_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_q = s_q.tx;

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // output pin shows ready only when idle and the mode bit is set
  always_comb begin
    if (ld_pend)
      DOUT = tx_q.word[23];
    else if (s_q.regs[REG_READY_ON_OUTPUT_SELECT][READY_ON_OUTPUT_SELECT_BIT] &&
             lk_q.out_left == 5'd0)
      DOUT = s_q.rdy_n; // [R23]
    else
      DOUT = lk_q.sh_out[23]; // [R10]
  end

  assign DATA_READY_N = s_q.rdy_n;
  assign CONV_RUN = s_q.running; // [R22]
  assign FILTER_CLEAR = s_q.fclr; // [R3]
  assign INPUT_SHORT = s_q.st == ST_CAL && s_q.cal == 2'd2; // [R18]
  assign CAL_KIND = s_q.cal;
  assign CAL_START = s_q.cal_go;
  assign IN_RESET = s_q.rst_cnt != 17'd0;
  assign OFFSET_COEF = s_q.ofs;
  assign FULL_SCALE_COEF = s_q.fs;

endmodule

// ### inc/scd_pkg.sv
// shared constants and carrier types for the serial command decoder
package scd_pkg;
  // command byte patterns, compared on the upper seven, the upper four or all eight bits
  localparam logic [6:0] CMD_WAKE = 7'h00;
  localparam logic [6:0] CMD_SLEEP = 7'h01;
  localparam logic [6:0] CMD_SYNC = 7'h02;
  localparam logic [6:0] CMD_RESET = 7'h03;
  localparam logic [6:0] CMD_RDATA = 7'h09;
  localparam logic [6:0] CMD_CONTINUOUS_READOUT_CMD = 7'h0a;
  localparam logic [6:0] CMD_STOP_CONTINUOUS_CMD = 7'h0b;
  localparam logic [3:0] CMD_REGISTER_READ_CMD_HI = 4'h2;
  localparam logic [3:0] CMD_REGISTER_WRITE_CMD_HI = 4'h4;
  localparam logic [7:0] CMD_SYSTEM_OFFSET_CAL_CMD = 8'h60;
  localparam logic [7:0] CMD_SYSTEM_GAIN_CAL_CMD = 8'h61;
  localparam logic [7:0] CMD_SELF_OFFSET_CAL_CMD = 8'h62;
  localparam logic [7:0] CMD_NOP = 8'hff;
  // register file
  localparam int NUM_REGS = 16;
  localparam logic [3:0] REG_READY_ON_OUTPUT_SELECT = 4'h0a;
  localparam int READY_ON_OUTPUT_SELECT_BIT = 3;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int RESULT_BITS = 24;
  // timing
  localparam real CLK_MHZ = 20.0;
  localparam real SOFT_RST_MS = 0.6;
  localparam int SOFT_RST_CYC = int'(SOFT_RST_MS * 1000.0 * CLK_MHZ);
  localparam int POR_CYC = 65536;
  // link-side events, carried across as toggles
  typedef struct packed {
    logic [7:0] byte_val;
    logic byte_tgl;
  } scd_rx_t;
  // shift-out load request from the system side
  typedef struct packed {
    logic [23:0] word;
    logic [4:0] nbits;
    logic load_tgl;
  } scd_tx_t;
endpackage

// ### sim/scd_asserts.sv
// port assertions for the serial command decoder
`timescale 1ns/1ps
module scd_asserts
  import scd_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
) (
  // system side
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CONV_DONE,
  input wire logic CAL_DONE,
  // decoder outputs
  input wire logic DATA_READY_N,
  input wire logic CONV_RUN,
  input wire logic INPUT_SHORT,
  input wire logic [1:0] CAL_KIND,
  input wire logic CAL_START,
  input wire logic IN_RESET,
  input wire logic [23:0] OFFSET_COEF,
  input wire logic [23:0] FULL_SCALE_COEF
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////
  // calibration start and coefficient updates
  a_cal_pulse: assert property (CAL_START |=> !CAL_START)
    else $error("calibration start too long");
  a_cal_kind: assert property (CAL_START |-> CAL_KIND != 2'h3)
    else $error("calibration kind out of range");
  a_short_self: assert property (INPUT_SHORT |-> CAL_KIND == 2'h2)
    else $error("inputs shorted outside self calibration");
  a_ofs_src: assert property ($changed(OFFSET_COEF) |-> IN_RESET ||
    $past(IN_RESET) || $past(CAL_DONE) || $past(CAL_DONE, 2) ||
    $past(CAL_DONE, 3)) else $error("offset coefficient moved alone");
  a_fsc_src: assert property ($changed(FULL_SCALE_COEF) |->
    IN_RESET || $past(IN_RESET) || $past(CAL_DONE) ||
    $past(CAL_DONE, 2) || $past(CAL_DONE, 3))
    else $error("full-scale coefficient moved alone");
  // reset hold, start-up mode and ready flag
  a_por_hold: assert property ($fell(SYS_RST) |=> IN_RESET [*8])
    else $error("power-up hold too short");
  a_run_after: assert property ($fell(IN_RESET) |-> ##[0:2] CONV_RUN)
    else $error("converter idle after reset");
  a_ready_set: assert property (CONV_DONE && !IN_RESET |->
    ##[1:4] !DATA_READY_N) else $error("data ready not shown");
endmodule
bind scd_top scd_asserts #(.POR_CYCLES(POR_CYCLES)) scd_asserts_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .CONV_DONE(CONV_DONE),
  .CAL_DONE(CAL_DONE), .DATA_READY_N(DATA_READY_N), .CONV_RUN(CONV_RUN),
  .INPUT_SHORT(INPUT_SHORT), .CAL_KIND(CAL_KIND), .CAL_START(CAL_START),
  .IN_RESET(IN_RESET), .OFFSET_COEF(OFFSET_COEF),
  .FULL_SCALE_COEF(FULL_SCALE_COEF));

// ### sim/scd_host.sv
// host-side serial bus model for the command decoder
`timescale 1ns/1ps
module scd_host (
  // serial link
  output logic SCLK,
  output logic CS_N,
  output logic DIN,
  input wire logic DOUT
);
  // link clock stands low outside frames
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    DIN = 1'b1;
  end
  // one byte, msb first; data sampled just before the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    CS_N = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      DIN = tx[i];
      #16 rx[i] = DOUT;
      SCLK = 1'b1;
      #16 SCLK = 1'b0;
    end
    #8 DIN = ~DIN; // released line must not keep its value
  endtask
  // chip select pulse realigns the shifter before a reset
  task automatic realign();
    CS_N = 1'b1;
    #100 CS_N = 1'b0;
  endtask
endmodule

// ### sim/scd_top_tb.sv
// self-checking bench for the serial command decoder
`timescale 1ns/1ps
module scd_top_tb;
  import scd_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, conv_done = 1'b0, cal_done = 1'b0;
  logic [23:0] conv_result = 24'h00_0000, cal_coef = 24'h00_0000, rd;
  logic sclk, cs_n, din, dout, data_ready_n_n, conv_run, filt_clr, in_short;
  logic cal_start, in_reset;
  logic [1:0] cal_kind;
  logic [23:0] ofs_coef, fsc_coef;
  logic [7:0] rb;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  scd_top #(.POR_CYCLES(64), .SOFT_RST_CYCLES(32)) scd_top_inst (
    .CLK(clk), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT(dout), .DATA_READY_N(data_ready_n_n), .CONV_DONE(conv_done),
    .CONV_RESULT(conv_result), .CAL_DONE(cal_done), .CAL_COEF(cal_coef),
    .CONV_RUN(conv_run), .FILTER_CLEAR(filt_clr), .INPUT_SHORT(in_short),
    .CAL_KIND(cal_kind), .CAL_START(cal_start), .IN_RESET(in_reset),
    .OFFSET_COEF(ofs_coef), .FULL_SCALE_COEF(fsc_coef));
  scd_host scd_host_inst (.SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout));
  always #25 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // byte plus the gap the decoder needs between bytes
  task automatic send(input logic [7:0] b);
    scd_host_inst.xfer(b, rb);
    tick(10);
  endtask
  task automatic rd24(output logic [23:0] v);
    for (int i = 2; i >= 0; i--) begin
      send(CMD_NOP);
      v[i*8 +: 8] = rb;
    end
  endtask
  // one finished conversion: done pulse for one clock, then six clocks of wait
  task automatic conv(input logic [23:0] v);
    conv_result = v;
    conv_done = 1'b1;
    tick();
    conv_done = 1'b0;
    tick(6);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    sys_rst = 1'b0;
    tick(60);
    chk_bit(in_reset, 1'b1);
    repeat (200) if (in_reset !== 1'b0) tick();
    chk_bit(conv_run, 1'b1);
    conv(24'ha5_c3f0);
    chk_bit(data_ready_n_n, 1'b0);
    rd24(rd);
    chk_val(rd, 24'ha5_c3f0);
    chk_bit(data_ready_n_n, 1'b1);
    $display("end of continuous readout");
    send({CMD_STOP_CONTINUOUS_CMD, 1'b1});
    for (int c = 0; c < 2; c++) begin
      conv(24'h12_3456 + 24'(c));
      send({CMD_RDATA, c[0]});
      rd24(rd);
      chk_val(rd, 24'h12_3456 + 24'(c));
    end
    $display("end of read once");
    send({CMD_REGISTER_WRITE_CMD_HI, 4'hf});
    send(8'h01);
    send(8'h5a);
    send(8'hc3);
    send({CMD_REGISTER_READ_CMD_HI, 4'hf});
    send(8'h01);
    send({CMD_SYNC, 1'b0});
    chk_val(24'(rb), 24'h00_005a);
    send(CMD_NOP);
    chk_val(24'(rb), 24'h00_00c3);
    send({CMD_REGISTER_WRITE_CMD_HI, REG_READY_ON_OUTPUT_SELECT});
    send(8'h00);
    send(8'h08);
    conv(24'hff_ffff);
    chk_bit(dout, 1'b0);
    $display("end of registers");
    scd_host_inst.xfer({CMD_SYNC, 1'b1}, rb);
    repeat (20) if (filt_clr !== 1'b1) tick();
    chk_bit(filt_clr, 1'b1);
    tick(10);
    send({CMD_SLEEP, 1'b1});
    chk_bit(conv_run, 1'b1);
    conv(24'h00_0000);
    chk_bit(conv_run, 1'b0);
    send(8'h30);
    chk_bit(conv_run, 1'b0);
    send({CMD_WAKE, 1'b1});
    chk_bit(conv_run, 1'b1);
    $display("end of power saving");
    for (int k = 0; k < 3; k++) begin
      scd_host_inst.xfer(CMD_SYSTEM_OFFSET_CAL_CMD + 8'(k), rb);
      repeat (30) if (cal_start !== 1'b1) tick();
      chk_bit(cal_start, 1'b1);
      chk_val(24'(cal_kind), 24'(k));
      chk_bit(in_short, k == 2);
      cal_coef = 24'h10_0001 << k;
      cal_done = 1'b1;
      tick();
      cal_done = 1'b0;
      tick(3);
      chk_val(k == 1 ? fsc_coef : ofs_coef, cal_coef);
      tick(10);
    end
    $display("end of calibration");
    scd_host_inst.realign();
    send({CMD_RESET, 1'b0});
    chk_bit(in_reset, 1'b1);
    repeat (100) if (in_reset !== 1'b0) tick();
    send({CMD_REGISTER_READ_CMD_HI, REG_READY_ON_OUTPUT_SELECT});
    send(8'h00);
    send(CMD_NOP);
    chk_val(24'(rb), 24'(REG_RESET_VAL));
    $display("end of soft reset");
    wrap_up();
  end
endmodule
